// >>> src/branch_unit_cfg.svh
`ifndef BRANCH_UNIT_CFG_SVH
`define BRANCH_UNIT_CFG_SVH

// ----------------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------------
`define OPC_MSB         31
`define OPC_LSB         26
`define DEST_MSB        25
`define DEST_LSB        21
`define DELAY_BIT       25
`define COND_MSB        24
`define COND_LSB        21
`define JMP_DELAY_BIT   20
`define JMP_ABS_BIT     19
`define JMP_LINK_BIT    18
`define IMM_MSB         15
`define IMM_LSB         0

// ----------------------------------------------------------------------
// opcodes and condition selectors
// ----------------------------------------------------------------------
`define OPC_COND_REG    6'h27
`define OPC_COND_IMM    6'h2f
`define OPC_JUMP_REG    6'h26
`define OPC_IMM_PREFIX  6'h2c
`define COND_NE         4'h1
`define COND_LT         4'h2
`define COND_LE         4'h3
`define COND_GT         4'h4

// ----------------------------------------------------------------------
// program counter step and cycle costs
// ----------------------------------------------------------------------
`define INSTR_STEP      32'h0000_0004
`define COST_NOT_TAKEN  2'h1
`define COST_DELAY      2'h2
`define COST_NO_DELAY   2'h3

`endif

// >>> src/branch_unit_pkg.sv
`include "branch_unit_cfg.svh"

package branch_unit_pkg;

  typedef logic [31:0] word_t;
  typedef logic [1:0]  cost_t;
  typedef logic [4:0]  reg_idx_t;

  typedef enum logic [3:0] {
    COND_NE = `COND_NE,
    COND_LT = `COND_LT,
    COND_LE = `COND_LE,
    COND_GT = `COND_GT
  } cond_sel_t;

  typedef enum logic [0:0] {
    ST_READY = 1'b0,
    ST_STALL = 1'b1
  } unit_state_t;

  // selector values this unit resolves
  function automatic logic cond_supported(input logic [3:0] sel);
    return (sel == `COND_NE) || (sel == `COND_LT) || (sel == `COND_LE) || (sel == `COND_GT);
  endfunction

endpackage

// >>> src/branch_cond_eval.sv
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module branch_cond_eval (
  input  wire logic [3:0]            sel,
  input  wire branch_unit_pkg::word_t value,
  output logic                       supported,
  output logic                       taken
);
  import branch_unit_pkg::*;

  logic is_zero;
  logic is_neg;

  // ----------------------------------------------------------------------
  // signed compare against zero
  // ----------------------------------------------------------------------
  assign is_zero   = (value == 32'h0000_0000);
  assign is_neg    = value[31];
  assign supported = cond_supported(sel);

  always_comb begin
    unique case (sel)
      `COND_GT: taken = !is_neg && !is_zero;
      `COND_LE: taken = is_neg || is_zero;
      `COND_LT: taken = is_neg;
      `COND_NE: taken = !is_zero;
      default:  taken = 1'b0;
    endcase
  end

endmodule

// >>> src/branch_target_calc.sv
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module branch_target_calc (
  input  wire branch_unit_pkg::word_t pc,
  input  wire branch_unit_pkg::word_t reg_offset,
  input  wire logic [15:0]           imm_field,
  input  wire logic                  prefix_valid,
  input  wire logic [15:0]           prefix_hi,
  input  wire logic                  use_imm,
  input  wire logic                  absolute,
  output branch_unit_pkg::word_t     target,
  output branch_unit_pkg::word_t     fall_through
);
  import branch_unit_pkg::*;

  word_t imm_word;
  word_t offset;

  // ----------------------------------------------------------------------
  // immediate widening and target sum
  // ----------------------------------------------------------------------
  assign imm_word     = prefix_valid ? {prefix_hi, imm_field}
                                     : {{16{imm_field[15]}}, imm_field};
  assign offset       = use_imm ? imm_word : reg_offset;
  assign target       = absolute ? offset : pc + offset;
  assign fall_through = pc + `INSTR_STEP;

endmodule

// >>> src/conditional_branch_unit.sv
// Notes on behaviour
// - greater-than forms branch only when the tested register is strictly above zero.
// - less-or-equal forms branch when the tested register is at or below zero.
// - less-than forms branch only when the tested register is strictly below zero.
// - not-equal forms branch whenever the tested register is not zero.
// - register forms jump to the current pc plus the offset register.
// - immediate forms jump to the current pc plus the immediate.
// - without a prefix the sixteen-bit immediate is sign extended to a word.
// - right after an upper-literal prefix the combined word immediate is used.
// - a false condition steps the pc by one word in a single cycle.
// - delay variants carry the delay flag set, plain variants carry it clear.
// - with delay flag set the following instruction completes before the target.
// - with delay flag clear a taken branch squashes the following instruction.
// - a taken branch with delay flag set costs two cycles.
// - a taken branch with delay flag clear costs three cycles.
// - unconditional jumps come relative or absolute, linking only with delay.
// - absolute jumps target the offset register itself, else pc plus it.
// - linking jumps write the jump's own pc to the destination register.
// - unconditional jumps cost two cycles with delay, three without.
`timescale 1ns/100ps
`include "branch_unit_cfg.svh"

module conditional_branch_unit (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   instr_valid,
  input  wire branch_unit_pkg::word_t instr,
  input  wire branch_unit_pkg::word_t instr_pc,
  input  wire branch_unit_pkg::word_t first_source_reg,
  input  wire branch_unit_pkg::word_t offset_operand_reg,
  output logic                        ready_reg,
  output logic                        result_valid_reg,
  output logic                        branch_taken_reg,
  output branch_unit_pkg::word_t      next_pc_reg,
  output branch_unit_pkg::cost_t      cycle_cost_reg,
  output logic                        squash_next_reg,
  output logic                        delay_slot_reg,
  output logic                        link_we_reg,
  output branch_unit_pkg::reg_idx_t   link_dest_reg,
  output branch_unit_pkg::word_t      link_data_reg,
  output logic                        illegal_reg
);
  import branch_unit_pkg::*;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [5:0]  opcode;
  logic        accept;
  logic        is_cond_reg;
  logic        is_cond_imm;
  logic        is_cond;
  logic        is_jump;
  logic        is_prefix;
  logic        cond_ok;
  logic        cond_true;
  logic        dec_delay;
  logic        dec_abs;
  logic        dec_link;
  logic        dec_branch;
  logic        dec_illegal;
  logic        dec_taken;
  cost_t       dec_cost;
  word_t       target;
  word_t       fall_through;
  logic        prefix_valid_reg;
  logic [15:0] prefix_hi_reg;
  unit_state_t state_reg;
  cost_t       stall_cnt_reg;

  assign opcode      = instr[`OPC_MSB:`OPC_LSB];
  assign accept      = instr_valid && ready_reg;
  assign is_cond_reg = (opcode == `OPC_COND_REG);
  assign is_cond_imm = (opcode == `OPC_COND_IMM);
  assign is_cond     = (is_cond_reg || is_cond_imm) && cond_ok;
  assign is_jump     = (opcode == `OPC_JUMP_REG);
  assign is_prefix   = (opcode == `OPC_IMM_PREFIX);

  // delay flag from the destination field for conditional forms
  assign dec_delay   = is_jump ? instr[`JMP_DELAY_BIT] : instr[`DELAY_BIT];
  assign dec_abs     = is_jump && instr[`JMP_ABS_BIT];
  assign dec_link    = is_jump && instr[`JMP_LINK_BIT];
  // linking without delay slot has no encoding
  assign dec_illegal = dec_link && !instr[`JMP_DELAY_BIT];
  assign dec_branch  = is_cond || (is_jump && !dec_illegal);
  assign dec_taken   = is_jump || cond_true;

  always_comb begin
    if (!dec_taken) begin
      dec_cost = `COST_NOT_TAKEN;
    end else if (dec_delay) begin
      dec_cost = `COST_DELAY;
    end else begin
      dec_cost = `COST_NO_DELAY;
    end
  end

  branch_cond_eval u_cond (
    .sel       (instr[`COND_MSB:`COND_LSB]),
    .value     (first_source_reg),
    .supported (cond_ok),
    .taken     (cond_true)
  );

  branch_target_calc u_target (
    .pc           (instr_pc),
    .reg_offset   (offset_operand_reg),
    .imm_field    (instr[`IMM_MSB:`IMM_LSB]),
    .prefix_valid (prefix_valid_reg),
    .prefix_hi    (prefix_hi_reg),
    .use_imm      (is_cond_imm),
    .absolute     (dec_abs),
    .target       (target),
    .fall_through (fall_through)
  );

  // ----------------------------------------------------------------------
  // upper-literal prefix capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prefix_valid_reg <= 1'b0;
      prefix_hi_reg    <= 16'h0000;
    end else if (accept) begin
      prefix_valid_reg <= is_prefix;
      if (is_prefix) begin
        prefix_hi_reg <= instr[`IMM_MSB:`IMM_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // occupancy: hold off new instructions for the branch cost
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_READY;
      stall_cnt_reg <= 2'h0;
      ready_reg     <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_READY: begin
          if (accept && dec_branch && dec_taken) begin
            state_reg     <= ST_STALL;
            stall_cnt_reg <= dec_cost - 2'h1;
            ready_reg     <= 1'b0;
          end
        end
        ST_STALL: begin
          if (stall_cnt_reg == 2'h1) begin
            state_reg     <= ST_READY;
            stall_cnt_reg <= 2'h0;
            ready_reg     <= 1'b1;
          end else begin
            stall_cnt_reg <= stall_cnt_reg - 2'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // resolution results
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_valid_reg <= 1'b0;
      branch_taken_reg <= 1'b0;
      next_pc_reg      <= 32'h0000_0000;
      cycle_cost_reg   <= 2'h0;
      squash_next_reg  <= 1'b0;
      delay_slot_reg   <= 1'b0;
      illegal_reg      <= 1'b0;
    end else begin
      result_valid_reg <= accept && dec_branch;
      illegal_reg      <= accept && is_jump && dec_illegal;
      squash_next_reg  <= 1'b0;
      delay_slot_reg   <= 1'b0;
      if (accept && dec_branch) begin
        branch_taken_reg <= dec_taken;
        next_pc_reg      <= dec_taken ? target : fall_through;
        cycle_cost_reg   <= dec_cost;
        squash_next_reg  <= dec_taken && !dec_delay;
        delay_slot_reg   <= dec_taken && dec_delay;
      end
    end
  end

  // ----------------------------------------------------------------------
  // link write, only for linking jumps
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_we_reg   <= 1'b0;
      link_dest_reg <= 5'h00;
      link_data_reg <= 32'h0000_0000;
    end else begin
      link_we_reg <= accept && dec_branch && dec_link;
      if (accept && dec_branch && dec_link) begin
        link_dest_reg <= instr[`DEST_MSB:`DEST_LSB];
        link_data_reg <= instr_pc;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_GT_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && instr[`COND_MSB:`COND_LSB] == `COND_GT
    |=> branch_taken_reg == ($signed($past(first_source_reg)) > 0))
    else $error("greater-than decision wrong");

  AST_LE_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && instr[`COND_MSB:`COND_LSB] == `COND_LE
    |=> branch_taken_reg == ($signed($past(first_source_reg)) <= 0))
    else $error("less-or-equal decision wrong");

  AST_LT_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && instr[`COND_MSB:`COND_LSB] == `COND_LT
    |=> branch_taken_reg == ($signed($past(first_source_reg)) < 0))
    else $error("less-than decision wrong");

  AST_NE_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && instr[`COND_MSB:`COND_LSB] == `COND_NE
    |=> branch_taken_reg == ($past(first_source_reg) != 32'h0000_0000))
    else $error("not-equal decision wrong");

  AST_REG_TARGET: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && is_cond_reg && cond_true
    |=> next_pc_reg == $past(instr_pc) + $past(offset_operand_reg))
    else $error("register-offset target wrong");

  AST_IMM_SEXT: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && is_cond_imm && cond_true && !prefix_valid_reg
    |=> next_pc_reg == $past(instr_pc) + {{16{$past(instr[15])}}, $past(instr[15:0])})
    else $error("sign-extended immediate target wrong");

  AST_IMM_PREFIX: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_prefix ##1 !accept ##1 accept && is_cond && is_cond_imm && cond_true
    |=> next_pc_reg == $past(instr_pc) + {$past(instr[15:0], 3), $past(instr[15:0])})
    else $error("prefixed immediate target wrong");

  AST_NOT_TAKEN: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && !cond_true
    |=> next_pc_reg == $past(instr_pc) + `INSTR_STEP && cycle_cost_reg == `COST_NOT_TAKEN && ready_reg)
    else $error("fall-through wrong");

  AST_COST_DELAY: assert property (@(posedge clk_sys) disable iff (rst)
    accept && dec_branch && dec_taken && dec_delay
    |=> !ready_reg && !squash_next_reg ##1 ready_reg)
    else $error("delayed taken cost not two cycles");

  AST_COST_NO_DELAY: assert property (@(posedge clk_sys) disable iff (rst)
    accept && dec_branch && dec_taken && !dec_delay
    |=> squash_next_reg && !ready_reg ##1 !ready_reg ##1 ready_reg)
    else $error("undelayed taken cost not three cycles");

  AST_ABS_TARGET: assert property (@(posedge clk_sys) disable iff (rst)
    accept && dec_branch && dec_abs |=> next_pc_reg == $past(offset_operand_reg))
    else $error("absolute jump target wrong");

  AST_LINK: assert property (@(posedge clk_sys) disable iff (rst)
    accept && dec_branch
    |=> link_we_reg == $past(dec_link) && (!link_we_reg || link_data_reg == $past(instr_pc)))
    else $error("link write wrong");

  AST_STALL_REFUSE: assert property (@(posedge clk_sys) disable iff (rst)
    !ready_reg |=> !result_valid_reg && !link_we_reg)
    else $error("instruction taken while stalled");

  AST_COND_DELAY_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond && cond_true
    |=> delay_slot_reg == $past(instr[`DELAY_BIT]) && squash_next_reg == !$past(instr[`DELAY_BIT]))
    else $error("conditional delay flag handling wrong");

  AST_JUMP_COST: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_jump && !(instr[`JMP_LINK_BIT] && !instr[`JMP_DELAY_BIT])
    |=> branch_taken_reg && delay_slot_reg == $past(instr[`JMP_DELAY_BIT])
        && cycle_cost_reg == ($past(instr[`JMP_DELAY_BIT]) ? `COST_DELAY : `COST_NO_DELAY))
    else $error("jump cost wrong");

  AST_REL_JUMP: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_jump && !instr[`JMP_ABS_BIT] && !(instr[`JMP_LINK_BIT] && !instr[`JMP_DELAY_BIT])
    |=> next_pc_reg == $past(instr_pc) + $past(offset_operand_reg))
    else $error("relative jump target wrong");

  AST_ILLEGAL: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_jump && instr[`JMP_LINK_BIT] && !instr[`JMP_DELAY_BIT]
    |=> illegal_reg && !result_valid_reg && !link_we_reg && ready_reg)
    else $error("link jump without delay not refused");

  AST_COND_NO_LINK: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_cond |=> !link_we_reg && !illegal_reg)
    else $error("conditional branch wrote a register");

  AST_UNSUPPORTED: assert property (@(posedge clk_sys) disable iff (rst)
    accept && (is_cond_reg || is_cond_imm)
    && !(instr[`COND_MSB:`COND_LSB] inside {`COND_NE, `COND_LT, `COND_LE, `COND_GT})
    |=> !result_valid_reg && ready_reg)
    else $error("unsupported selector resolved");

  AST_PREFIX_ARM: assert property (@(posedge clk_sys) disable iff (rst)
    accept && is_prefix |=> prefix_valid_reg && !result_valid_reg)
    else $error("prefix not armed");

  AST_PREFIX_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    accept && !is_prefix |=> !prefix_valid_reg)
    else $error("prefix not cleared");

endmodule

// >>> test/conditional_branch_unit_test.sv
`timescale 1ns/100ps

module conditional_branch_unit_test;
  import branch_unit_pkg::*;

  logic     clk_sys            = 1'b0;
  logic     rst                = 1'b1;
  logic     instr_valid        = 1'b0;
  word_t    instr              = 32'h0000_0000;
  word_t    instr_pc           = 32'h0000_0000;
  word_t    first_source_reg   = 32'h0000_0000;
  word_t    offset_operand_reg = 32'h0000_0000;
  logic     ready_reg;
  logic     result_valid_reg;
  logic     branch_taken_reg;
  word_t    next_pc_reg;
  cost_t    cycle_cost_reg;
  logic     squash_next_reg;
  logic     delay_slot_reg;
  logic     link_we_reg;
  reg_idx_t link_dest_reg;
  word_t    link_data_reg;
  logic     illegal_reg;
  int       error_cnt          = 0;
  int       tests_run          = 0;

  conditional_branch_unit uut (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .instr_valid        (instr_valid),
    .instr              (instr),
    .instr_pc           (instr_pc),
    .first_source_reg   (first_source_reg),
    .offset_operand_reg (offset_operand_reg),
    .ready_reg          (ready_reg),
    .result_valid_reg   (result_valid_reg),
    .branch_taken_reg   (branch_taken_reg),
    .next_pc_reg        (next_pc_reg),
    .cycle_cost_reg     (cycle_cost_reg),
    .squash_next_reg    (squash_next_reg),
    .delay_slot_reg     (delay_slot_reg),
    .link_we_reg        (link_we_reg),
    .link_dest_reg      (link_dest_reg),
    .link_data_reg      (link_data_reg),
    .illegal_reg        (illegal_reg)
  );

  always #10 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // offers one instruction, returns just after the accepting edge
  task automatic issue(input word_t i, input word_t pc, input word_t a, input word_t b);
    int n;
    n = 0;
    while (ready_reg !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(ready_reg, 1'b1);
    @(posedge clk_sys);
    instr              <= i;
    instr_pc           <= pc;
    first_source_reg   <= a;
    offset_operand_reg <= b;
    instr_valid        <= 1'b1;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic branch_check(input logic tk, input word_t pc, input word_t tgt, input logic d);
    chk(result_valid_reg, 1'b1);
    chk(branch_taken_reg, tk);
    chk(next_pc_reg, tk ? tgt : pc + 32'h4);
    chk(cycle_cost_reg, !tk ? 2'h1 : d ? 2'h2 : 2'h3);
    chk(squash_next_reg, tk && !d);
    chk(delay_slot_reg, tk && d);
    chk(ready_reg, !tk);
    if (tk && !d) begin
      @(posedge clk_sys);
      #1;
      chk(ready_reg, 1'b0);
    end
    if (tk) begin
      @(posedge clk_sys);
      #1;
      chk(ready_reg, 1'b1);
      chk(result_valid_reg, 1'b0);
    end
  endtask

  function automatic logic exp_taken(input logic [3:0] sel, input word_t v);
    case (sel)
      4'h1: return v != 32'h0;
      4'h2: return $signed(v) < 0;
      4'h3: return $signed(v) <= 0;
      default: return $signed(v) > 0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_cond_reg();
    word_t vals[5];
    word_t pc;
    logic  d;
    vals = '{32'h8000_0000, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0001, 32'h7fff_ffff};
    for (int s = 1; s <= 4; s++) begin
      for (int k = 0; k < 5; k++) begin
        pc = 32'h0000_1000 + 32'(s * 64 + k * 8);
        d  = 1'((s + k) % 2);
        issue({6'h27, d, 4'(s), 5'h03, 5'h04, 11'h000}, pc, vals[k], 32'hffff_fff0);
        chk(link_we_reg, 1'b0);
        branch_check(exp_taken(4'(s), vals[k]), pc, pc + 32'hffff_fff0, d);
      end
    end
  endtask

  task automatic test_cond_imm();
    issue({6'h2f, 1'b0, 4'h1, 5'h03, 16'h8000}, 32'h0000_2000, 32'h1, 32'h5555_5555);
    branch_check(1'b1, 32'h0000_2000, 32'hffff_a000, 1'b0);
    issue({6'h2f, 1'b1, 4'h4, 5'h03, 16'h0040}, 32'h0000_3000, 32'h2, 32'h5555_5555);
    branch_check(1'b1, 32'h0000_3000, 32'h0000_3040, 1'b1);
  endtask

  task automatic test_prefix();
    issue({6'h2c, 10'h000, 16'h1234}, 32'h0000_4000, 32'h0, 32'h0);
    chk(result_valid_reg, 1'b0);
    issue({6'h2f, 1'b0, 4'h1, 5'h03, 16'h5678}, 32'h0000_4004, 32'h5, 32'h0);
    branch_check(1'b1, 32'h0000_4004, 32'h1234_967c, 1'b0);
    issue({6'h2c, 10'h000, 16'h1234}, 32'h0000_5000, 32'h0, 32'h0);
    issue({6'h27, 1'b0, 4'h1, 5'h03, 5'h04, 11'h000}, 32'h0000_5004, 32'h0, 32'h10);
    branch_check(1'b0, 32'h0000_5004, 32'h0, 1'b0);
    issue({6'h2f, 1'b1, 4'h2, 5'h03, 16'hfffc}, 32'h0000_5008, 32'hffff_fffe, 32'h0);
    branch_check(1'b1, 32'h0000_5008, 32'h0000_5004, 1'b1);
  endtask

  task automatic test_jumps();
    word_t pc;
    word_t tgt;
    for (int m = 0; m < 4; m++) begin
      pc  = 32'h0000_6000 + 32'(m * 16);
      tgt = m[1] ? 32'h0000_0300 : pc + 32'h0000_0300;
      issue({6'h26, 5'h07, m[0], m[1], 1'b0, 18'h0}, pc, 32'h0, 32'h0000_0300);
      chk(link_we_reg, 1'b0);
      branch_check(1'b1, pc, tgt, m[0]);
    end
    for (int m = 0; m < 2; m++) begin
      pc  = 32'h0000_7000 + 32'(m * 16);
      tgt = m[0] ? 32'h0000_0800 : pc + 32'h0000_0800;
      issue({6'h26, 5'h09, 1'b1, m[0], 1'b1, 18'h0}, pc, 32'h0, 32'h0000_0800);
      chk(link_we_reg, 1'b1);
      chk(link_dest_reg, 5'h09);
      chk(link_data_reg, pc);
      branch_check(1'b1, pc, tgt, 1'b1);
    end
    issue({6'h26, 5'h09, 1'b0, 1'b0, 1'b1, 18'h0}, 32'h0000_7100, 32'h0, 32'h0000_0800);
    chk(illegal_reg, 1'b1);
    chk(result_valid_reg, 1'b0);
    chk(link_we_reg, 1'b0);
  endtask

  task automatic test_unsupported();
    issue({6'h27, 1'b0, 4'h0, 5'h03, 5'h04, 11'h000}, 32'h0000_8000, 32'h0, 32'h10);
    chk(result_valid_reg, 1'b0);
    issue({6'h2f, 1'b1, 4'h5, 5'h03, 16'h0010}, 32'h0000_8004, 32'h1, 32'h0);
    chk(result_valid_reg, 1'b0);
    chk(ready_reg, 1'b1);
  endtask

  // reset in mid-run must drop an armed prefix
  task automatic test_reset_mid();
    issue({6'h2c, 10'h000, 16'h1234}, 32'h0000_9000, 32'h0, 32'h0);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(ready_reg, 1'b1);
    chk(result_valid_reg, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b0;
    issue({6'h2f, 1'b0, 4'h1, 5'h03, 16'h0010}, 32'h0000_9004, 32'h1, 32'h0);
    branch_check(1'b1, 32'h0000_9004, 32'h0000_9014, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (9) @(posedge clk_sys);
    #1;
    chk(ready_reg, 1'b1);
    chk(result_valid_reg, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b0;
    test_cond_reg();
    test_cond_imm();
    test_prefix();
    test_jumps();
    test_unsupported();
    test_reset_mid();
    test_done();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done();
  end

endmodule
